// [design/escape_link_ctrl.sv]
// escape-sequence link status controller with its forwarding fifo
//
// Summary of operation
// - connected: host characters go to the remote except a run of three escapes; commands refused except escape
// - escape characters are never echoed back to the host while connected
// - escape character pauses forwarding; up to two more characters are collected before deciding
// - mismatch resumes forwarding: held escapes first, then later characters, in order
// - three escapes in a row: connected to standby, nothing forwarded, even mid-data
// - forwarding held from an escape until the next non-escape host character; nothing sent early
// - escape character resets to plus; the set-escape command replaces it
// - resume-online moves standby to connected, no response text
// - cancel aborts scanning, enters standby, answers OK
// - wait-for-remote enables scanning and enters pending
// - a release after a waited connection returns to pending, which only cancel or a new connection then leaves
// - plain wait-for-remote equals scan selector three with no time limit
// - a remote connecting while waiting gives CONNECT with its address
// - operation status is exactly one of standby, pending, connected
// - selector three enables inquiry and page scan; timeout zero waits forever

module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg];

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      case ({push, pop})
        2'b10:   count_reg <= count_reg + 1'b1;
        2'b01:   count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end
endmodule

module escape_link_ctrl #(
  parameter int SECOND_CYCLES = esc_link_pkg::SECOND_CYCLES,
  parameter int FIFO_DEPTH    = esc_link_pkg::FIFO_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // host character stream
  input  wire logic        host_valid,
  output logic             host_ready,
  input  wire logic [7:0]  host_data,
  // decoded host commands
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_code,
  input  wire logic [7:0]  cmd_arg,
  input  wire logic [15:0] cmd_timeout,
  // responses to host
  output logic             resp_valid,
  output logic [1:0]       resp_code,
  output logic [47:0]      resp_addr,
  // remote radio side
  output logic             rf_valid,
  input  wire logic        rf_ready,
  output logic [7:0]       rf_data,
  input  wire logic        remote_connect,
  input  wire logic [47:0] remote_addr,
  input  wire logic        remote_release,
  output logic             inquiry_scan_en,
  output logic             page_scan_en,
  output logic [2:0]       op_status
);
  localparam logic [1:0] ESC_LAST = esc_link_pkg::ESC_RUN_LEN - 2'h1;

  esc_link_pkg::op_status_t status_reg;
  logic [7:0]               esc_char_reg;
  logic [1:0]               esc_cnt_reg;
  logic [7:0]               hold_buf_reg [2];
  logic [1:0]               drain_idx_reg;
  logic [7:0]               tail_reg;
  logic                     draining_reg;
  logic                     waited_reg;
  logic                     inq_reg;
  logic                     page_reg;
  logic [15:0]              to_left_reg;
  logic                     to_armed_reg;
  logic [31:0]              sec_cnt_reg;
  logic                     resp_valid_reg;
  logic [1:0]               resp_code_reg;
  logic [47:0]              resp_addr_reg;

  logic                     fifo_in_valid;
  logic                     fifo_in_ready;
  logic [7:0]               fifo_in_data;
  logic                     connected;
  logic                     char_take;
  logic                     is_esc;
  logic                     cmd_take;
  logic                     drain_last;
  logic                     timed_out;
  logic                     sec_tick;

  assign connected  = (status_reg == esc_link_pkg::ST_CONNECTED);
  // characters stall while the fifo is full or a held run is being replayed
  assign host_ready = connected ? (fifo_in_ready && !draining_reg) : 1'b1;
  assign char_take  = connected && host_valid && host_ready;
  assign is_esc     = (host_data == esc_char_reg);
  // commands are ignored while connected; escape handling is in-band
  assign cmd_take   = cmd_valid && !connected;
  assign drain_last = (drain_idx_reg == esc_cnt_reg);
  assign sec_tick   = (sec_cnt_reg == 32'(SECOND_CYCLES - 1));
  assign timed_out  = to_armed_reg && sec_tick && (to_left_reg == 16'h0001);

  // fifo input: direct pass-through, or replay of held escapes then the breaking char
  always_comb begin
    fifo_in_valid = 1'b0;
    fifo_in_data  = host_data;
    if (draining_reg) begin
      fifo_in_valid = 1'b1;
      fifo_in_data  = drain_last ? tail_reg : hold_buf_reg[drain_idx_reg[0]];
    end else if (char_take && esc_cnt_reg == 2'h0 && !is_esc) begin
      fifo_in_valid = 1'b1;
    end
  end

  // escape detector: count, hold buffer and replay
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      esc_cnt_reg     <= 2'h0;
      hold_buf_reg[0] <= 8'h00;
      hold_buf_reg[1] <= 8'h00;
      drain_idx_reg   <= 2'h0;
      tail_reg        <= 8'h00;
      draining_reg    <= 1'b0;
    end else if (draining_reg) begin
      if (fifo_in_ready) begin
        if (drain_last) begin
          draining_reg  <= 1'b0;
          esc_cnt_reg   <= 2'h0;
          drain_idx_reg <= 2'h0;
        end else begin
          drain_idx_reg <= drain_idx_reg + 1'b1;
        end
      end
    end else if (!connected) begin
      esc_cnt_reg <= 2'h0;
    end else if (char_take && is_esc) begin
      if (esc_cnt_reg == ESC_LAST) begin
        esc_cnt_reg <= 2'h0;
      end else begin
        // held, never echoed nor forwarded until the run is decided
        hold_buf_reg[esc_cnt_reg[0]] <= host_data;
        esc_cnt_reg                  <= esc_cnt_reg + 1'b1;
      end
    end else if (char_take && esc_cnt_reg != 2'h0) begin
      tail_reg      <= host_data;
      draining_reg  <= 1'b1;
      drain_idx_reg <= 2'h0;
    end
  end

  // escape character
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      esc_char_reg <= esc_link_pkg::ESC_CHAR_RESET;
    end else if (cmd_take && cmd_code == esc_link_pkg::CMD_SET_ESC) begin
      esc_char_reg <= cmd_arg;
    end
  end

  // operation status
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_reg <= esc_link_pkg::ST_STANDBY;
      waited_reg <= 1'b0;
    end else begin
      unique case (status_reg)
        esc_link_pkg::ST_STANDBY: begin
          if (cmd_take && cmd_code == esc_link_pkg::CMD_RESUME_ONLINE) begin
            status_reg <= esc_link_pkg::ST_CONNECTED;
          end else if (cmd_take && (cmd_code == esc_link_pkg::CMD_WAIT_DEFAULT ||
                                    cmd_code == esc_link_pkg::CMD_WAIT_PARAM)) begin
            status_reg <= esc_link_pkg::ST_PENDING;
            waited_reg <= 1'b1;
          end
        end
        esc_link_pkg::ST_PENDING: begin
          if (cmd_take && cmd_code == esc_link_pkg::CMD_CANCEL_TASK) begin
            status_reg <= esc_link_pkg::ST_STANDBY;
            waited_reg <= 1'b0;
          end else if (timed_out) begin
            status_reg <= esc_link_pkg::ST_STANDBY;
            waited_reg <= 1'b0;
          end else if (remote_connect) begin
            status_reg <= esc_link_pkg::ST_CONNECTED;
          end
        end
        esc_link_pkg::ST_CONNECTED: begin
          if (remote_release) begin
            status_reg <= waited_reg ? esc_link_pkg::ST_PENDING : esc_link_pkg::ST_STANDBY;
          end else if (char_take && is_esc && esc_cnt_reg == ESC_LAST) begin
            status_reg <= esc_link_pkg::ST_STANDBY;
          end
        end
        default: begin
          status_reg <= esc_link_pkg::ST_STANDBY;
        end
      endcase
    end
  end

  // scan enables and wait timer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      inq_reg      <= 1'b0;
      page_reg     <= 1'b0;
      to_left_reg  <= 16'h0000;
      to_armed_reg <= 1'b0;
      sec_cnt_reg  <= 32'h0000_0000;
    end else begin
      sec_cnt_reg <= sec_tick ? 32'h0000_0000 : sec_cnt_reg + 32'h0000_0001;
      if (cmd_take && status_reg == esc_link_pkg::ST_STANDBY &&
          cmd_code == esc_link_pkg::CMD_WAIT_DEFAULT) begin
        inq_reg      <= 1'b1;
        page_reg     <= 1'b1;
        to_armed_reg <= 1'b0;
        sec_cnt_reg  <= 32'h0000_0000;
      end else if (cmd_take && status_reg == esc_link_pkg::ST_STANDBY &&
                   cmd_code == esc_link_pkg::CMD_WAIT_PARAM) begin
        inq_reg      <= cmd_arg[esc_link_pkg::SCAN_SEL_BIT_INQ];
        page_reg     <= cmd_arg[esc_link_pkg::SCAN_SEL_BIT_PAGE];
        to_left_reg  <= cmd_timeout;
        to_armed_reg <= (cmd_timeout != esc_link_pkg::TIMEOUT_FOREVER);
        sec_cnt_reg  <= 32'h0000_0000;
      end else if (status_reg != esc_link_pkg::ST_PENDING ||
                   (cmd_take && cmd_code == esc_link_pkg::CMD_CANCEL_TASK)) begin
        // scanning only runs while pending; a connection also stops the time limit
        inq_reg      <= (status_reg == esc_link_pkg::ST_PENDING) ? 1'b0 : inq_reg && waited_reg;
        page_reg     <= (status_reg == esc_link_pkg::ST_PENDING) ? 1'b0 : page_reg && waited_reg;
        to_armed_reg <= 1'b0;
      end else if (remote_connect || timed_out) begin
        to_armed_reg <= 1'b0;
      end else if (to_armed_reg && sec_tick) begin
        to_left_reg <= to_left_reg - 16'h0001;
      end
    end
  end

  // responses: one-cycle pulse with registered code and address
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      resp_valid_reg <= 1'b0;
      resp_code_reg  <= esc_link_pkg::RESP_OK;
      resp_addr_reg  <= 48'h0000_0000_0000;
    end else begin
      resp_valid_reg <= 1'b0;
      if (cmd_take) begin
        unique case (cmd_code)
          esc_link_pkg::CMD_SET_ESC: begin
            resp_valid_reg <= 1'b1;
            resp_code_reg  <= esc_link_pkg::RESP_OK;
          end
          esc_link_pkg::CMD_RESUME_ONLINE: begin
            // silent on success; only a refused resume speaks
            resp_valid_reg <= (status_reg != esc_link_pkg::ST_STANDBY);
            resp_code_reg  <= esc_link_pkg::RESP_ERROR;
          end
          esc_link_pkg::CMD_CANCEL_TASK: begin
            resp_valid_reg <= 1'b1;
            resp_code_reg  <= esc_link_pkg::RESP_OK;
          end
          esc_link_pkg::CMD_WAIT_DEFAULT, esc_link_pkg::CMD_WAIT_PARAM: begin
            resp_valid_reg <= 1'b1;
            resp_code_reg  <= (status_reg == esc_link_pkg::ST_STANDBY) ? esc_link_pkg::RESP_OK
                                                                        : esc_link_pkg::RESP_ERROR;
          end
          default: begin
            resp_valid_reg <= 1'b0;
          end
        endcase
      end else if (status_reg == esc_link_pkg::ST_PENDING && timed_out) begin
        resp_valid_reg <= 1'b1;
        resp_code_reg  <= esc_link_pkg::RESP_ERROR;
      end else if (status_reg == esc_link_pkg::ST_PENDING && remote_connect) begin
        resp_valid_reg <= 1'b1;
        resp_code_reg  <= esc_link_pkg::RESP_CONNECT;
        resp_addr_reg  <= remote_addr;
      end
    end
  end

  stream_fifo #(
    .WIDTH (esc_link_pkg::CHAR_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (rf_valid),
    .out_ready (rf_ready),
    .out_data  (rf_data)
  );

  assign resp_valid      = resp_valid_reg;
  assign resp_code       = resp_code_reg;
  assign resp_addr       = resp_addr_reg;
  assign inquiry_scan_en = inq_reg && (status_reg == esc_link_pkg::ST_PENDING);
  assign page_scan_en    = page_reg && (status_reg == esc_link_pkg::ST_PENDING);
  assign op_status       = status_reg;
endmodule

// [include/esc_link_pkg.sv]
// shared constants and types for the escape-sequence link status controller
package esc_link_pkg;

  // operation status, one-hot
  typedef enum logic [2:0] {
    ST_STANDBY   = 3'b001,
    ST_PENDING   = 3'b010,
    ST_CONNECTED = 3'b100
  } op_status_t;

  // decoded host commands
  typedef enum logic [2:0] {
    CMD_NONE          = 3'h0,
    CMD_SET_ESC       = 3'h1,
    CMD_RESUME_ONLINE = 3'h2,
    CMD_CANCEL_TASK   = 3'h3,
    CMD_WAIT_DEFAULT  = 3'h4,
    CMD_WAIT_PARAM    = 3'h5
  } cmd_t;

  // responses to the host
  typedef enum logic [1:0] {
    RESP_OK      = 2'h0,
    RESP_CONNECT = 2'h1,
    RESP_ERROR   = 2'h2
  } resp_t;

  localparam logic [7:0]  ESC_CHAR_RESET     = 8'h2B;
  localparam logic [1:0]  ESC_RUN_LEN        = 2'h3;
  localparam logic [1:0]  SCAN_SEL_INQUIRY   = 2'h1;
  localparam logic [1:0]  SCAN_SEL_PAGE      = 2'h2;
  localparam logic [1:0]  SCAN_SEL_BOTH      = 2'h3;
  localparam logic [15:0] TIMEOUT_FOREVER    = 16'h0000;
  localparam logic [7:0]  PRINTABLE_LO       = 8'h20;
  localparam logic [7:0]  PRINTABLE_HI       = 8'h7E;
  localparam int          SCAN_SEL_BIT_INQ   = 0;
  localparam int          SCAN_SEL_BIT_PAGE  = 1;

  localparam int          CLK_HZ             = 20_000_000;
  localparam int          TIMEOUT_UNIT_S     = 1;
  localparam int          SECOND_CYCLES      = CLK_HZ * TIMEOUT_UNIT_S;
  localparam int          FIFO_DEPTH         = 8;
  localparam int          CHAR_WIDTH         = 8;

endpackage

// [test/escape_link_ctrl_assertions.sv]
// concurrent checks on the link status controller ports
module escape_link_ctrl_checker #(
  parameter int SECOND_CYCLES = esc_link_pkg::SECOND_CYCLES,
  parameter int FIFO_DEPTH    = esc_link_pkg::FIFO_DEPTH
) (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        host_valid,
  input wire logic        host_ready,
  input wire logic [7:0]  host_data,
  input wire logic        cmd_valid,
  input wire logic [2:0]  cmd_code,
  input wire logic [7:0]  cmd_arg,
  input wire logic        resp_valid,
  input wire logic [1:0]  resp_code,
  input wire logic [47:0] resp_addr,
  input wire logic        remote_connect,
  input wire logic [47:0] remote_addr,
  input wire logic        remote_release,
  input wire logic        inquiry_scan_en,
  input wire logic        page_scan_en,
  input wire logic [2:0]  op_status
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] STB = esc_link_pkg::ST_STANDBY;
  localparam logic [2:0] PND = esc_link_pkg::ST_PENDING;
  localparam logic [2:0] CON = esc_link_pkg::ST_CONNECTED;
  logic [7:0] esc_reg;
  logic       waited_reg;
  wire logic  taken = cmd_valid && op_status != CON;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // escape followed here so the triple check tracks reprogramming
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) esc_reg <= esc_link_pkg::ESC_CHAR_RESET;
    else if (taken && cmd_code == 3'h1) esc_reg <= cmd_arg;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) waited_reg <= 1'b0;
    else if (remote_connect && op_status == PND) waited_reg <= 1'b1;
    else if (taken && cmd_code == 3'h2) waited_reg <= 1'b0;
  end
  sequence s_esc_take;
    host_valid && host_ready && op_status == CON && host_data == esc_reg;
  endsequence
  sequence s_wait_taken;
    taken && op_status == STB && (cmd_code == 3'h4 || cmd_code == 3'h5 && cmd_arg == 8'h03);
  endsequence
  a_status_onehot:
    assert property ($onehot(op_status)) else $error("status not one-hot");
  a_wait_pending:
    assert property (s_wait_taken |=> op_status == PND && inquiry_scan_en && page_scan_en
      && resp_valid && resp_code == esc_link_pkg::RESP_OK) else $error("wait did not enter pending");
  a_cancel_standby:
    assert property (taken && cmd_code == 3'h3 |=> op_status == STB && resp_valid
      && resp_code == esc_link_pkg::RESP_OK && {inquiry_scan_en, page_scan_en} == 2'b00)
    else $error("cancel did not reach standby");
  a_resume_silent:
    assert property (taken && cmd_code == 3'h2 && op_status == STB |=> op_status == CON && !resp_valid)
    else $error("resume wrong");
  a_connect_report:
    assert property (remote_connect && op_status == PND |=> op_status == CON && resp_valid
      && resp_code == esc_link_pkg::RESP_CONNECT && resp_addr == $past(remote_addr))
    else $error("connect report wrong");
  a_online_deaf:
    assert property (cmd_valid && op_status == CON |=> !resp_valid) else $error("command answered online");
  a_release_return:
    assert property (remote_release && op_status == CON && waited_reg |=> op_status == PND)
    else $error("release did not return to pending");
  a_triple_standby:
    assert property (s_esc_take ##1 s_esc_take ##1 s_esc_take |=> op_status == STB)
    else $error("triple escape kept link");
endmodule
bind escape_link_ctrl escape_link_ctrl_checker #(.SECOND_CYCLES(SECOND_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_checker (
  .clk_sys(clk_sys), .nrst(nrst), .host_valid(host_valid), .host_ready(host_ready), .host_data(host_data),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .resp_valid(resp_valid),
  .resp_code(resp_code), .resp_addr(resp_addr), .remote_connect(remote_connect), .remote_addr(remote_addr),
  .remote_release(remote_release), .inquiry_scan_en(inquiry_scan_en), .page_scan_en(page_scan_en),
  .op_status(op_status)
);

// [test/remote_peer.sv]
// remote peer model: drains forwarded characters, makes and drops the link
module remote_peer (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        rf_valid,
  input  wire logic [7:0]  rf_data,
  output logic             rf_ready,
  output logic             remote_connect,
  output logic [47:0]      remote_addr,
  output logic             remote_release
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  // mode 0 always ready, 1 random stalls, 2 stalled
  int         mode = 0;
  initial begin
    rf_ready = 1'b1;
    {remote_connect, remote_release, remote_addr} = '0;
  end
  always @(posedge clk_sys) begin
    if (nrst && rf_valid && rf_ready) rx_q.push_back(rf_data);
    #5 rf_ready = (mode == 0) || (mode == 1 && $urandom % 2 == 1);
  end
  task automatic link_up(input logic [47:0] a);
    remote_addr = a;
    remote_connect = 1'b1;
    @(posedge clk_sys);
    #5 remote_connect = 1'b0;
    // address not held once the pulse is over
    remote_addr = ~a;
  endtask
  task automatic link_down();
    remote_release = 1'b1;
    @(posedge clk_sys);
    #5 remote_release = 1'b0;
  endtask
endmodule

// [test/testbench.sv]
// self-checking bench for the escape-sequence link status controller
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] chr_q_t[$];
  localparam int         SEC = 10;
  localparam logic [2:0] STB = esc_link_pkg::ST_STANDBY;
  localparam logic [2:0] PND = esc_link_pkg::ST_PENDING;
  localparam logic [2:0] CON = esc_link_pkg::ST_CONNECTED;
  localparam logic [1:0] R_OK = esc_link_pkg::RESP_OK;
  logic        clk_sys, nrst, host_valid, host_ready, cmd_valid, resp_valid, got_resp;
  logic        rf_valid, rf_ready, remote_connect, remote_release, inquiry_scan_en, page_scan_en;
  logic [7:0]  host_data, cmd_arg, rf_data, esc;
  logic [2:0]  cmd_code, op_status;
  logic [15:0] cmd_timeout;
  logic [1:0]  resp_code, got_code;
  logic [47:0] resp_addr, remote_addr, addr;
  int          num_errors = 0;
  int          n_compared = 0;
  chr_q_t      s;
  escape_link_ctrl #(.SECOND_CYCLES(SEC), .FIFO_DEPTH(8)) i_escape_link_ctrl (
    .clk_sys(clk_sys), .nrst(nrst), .host_valid(host_valid), .host_ready(host_ready), .host_data(host_data),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_timeout(cmd_timeout),
    .resp_valid(resp_valid), .resp_code(resp_code), .resp_addr(resp_addr), .rf_valid(rf_valid),
    .rf_ready(rf_ready), .rf_data(rf_data), .remote_connect(remote_connect), .remote_addr(remote_addr),
    .remote_release(remote_release), .inquiry_scan_en(inquiry_scan_en), .page_scan_en(page_scan_en),
    .op_status(op_status));
  remote_peer u_remote (.clk_sys(clk_sys), .nrst(nrst), .rf_valid(rf_valid), .rf_data(rf_data),
    .rf_ready(rf_ready), .remote_connect(remote_connect), .remote_addr(remote_addr),
    .remote_release(remote_release));
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%0h want=%0h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic chr_q_t to_q(input string t);
    chr_q_t q;
    foreach (t[i]) q.push_back(t[i]);
    return q;
  endfunction
  function automatic chr_q_t expect_fwd(input chr_q_t q, input logic [7:0] e, output bit stby);
    chr_q_t w;
    int     n;
    n = 0;
    stby = 1'b0;
    foreach (q[i]) begin
      if (stby) continue;
      if (q[i] == e) begin
        n++;
        stby = (n == 3);
      end else begin
        repeat (n) w.push_back(e);
        w.push_back(q[i]);
        n = 0;
      end
    end
    return w;
  endfunction
  task automatic send_char(input logic [7:0] c);
    bit ok;
    int n;
    host_valid = 1'b1;
    host_data = c;
    n = 0;
    do begin
      @(negedge clk_sys);
      ok = host_ready;
      @(posedge clk_sys);
    end while (!ok && n++ < 500);
    #5;
  endtask
  task automatic do_cmd(input logic [2:0] c, input logic [7:0] a);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_arg = a;
    @(posedge clk_sys);
    #5 cmd_valid = 1'b0;
    got_resp = resp_valid;
    got_code = resp_code;
    @(posedge clk_sys) #5;
  endtask
  task automatic run_stream(input chr_q_t q, input logic [7:0] e);
    chr_q_t want;
    bit     stby;
    int     n;
    want = expect_fwd(q, e, stby);
    u_remote.rx_q.delete();
    foreach (q[i]) begin
      send_char(q[i]);
      if (i == 0 && q[0] == e) begin
        host_valid = 1'b0;
        repeat (10) @(posedge clk_sys);
        #5 check(u_remote.rx_q.size(), 0);
      end
    end
    host_valid = 1'b0;
    if (u_remote.mode == 2) begin
      check(host_ready, 1'b0);
      u_remote.mode = 1;
    end
    n = 0;
    while (u_remote.rx_q.size() < want.size() && n++ < 500) @(posedge clk_sys);
    // spare cycles so a wrongly forwarded character still shows
    repeat (6) @(posedge clk_sys);
    #5 check(u_remote.rx_q.size(), want.size());
    foreach (want[i]) check(u_remote.rx_q[i], want[i]);
    check(op_status, stby ? STB : CON);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #1_000_000;
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(32'hEDAC));
    {nrst, host_valid, cmd_valid, host_data, cmd_code, cmd_arg, cmd_timeout} = '0;
    esc = esc_link_pkg::ESC_CHAR_RESET;
    repeat (4) @(posedge clk_sys);
    #5 nrst = 1'b1;
    check({op_status, inquiry_scan_en, page_scan_en, resp_valid}, {STB, 3'b000});
    do_cmd(3'h2, 8'h00);
    check({got_resp, op_status}, {1'b0, CON});
    do_cmd(3'h4, 8'h00);
    check({got_resp, op_status}, {1'b0, CON});
    run_stream(to_q("+a++b+x+y++z+++qq"), esc);
    do_cmd(3'h1, 8'h2A);
    check({got_resp, got_code}, {1'b1, R_OK});
    esc = 8'h2A;
    u_remote.mode = 2;
    do_cmd(3'h2, 8'h00);
    run_stream(to_q("ABCDEFGH"), esc);
    run_stream(to_q("+*a**+***b"), esc);
    for (int k = 0; k < 8; k++) begin
      esc = 8'h20 + 8'($urandom % 95);
      do_cmd(3'h1, esc);
      check({got_resp, got_code}, {1'b1, R_OK});
      do_cmd(3'h2, 8'h00);
      s = {};
      repeat (10 + $urandom % 20) s.push_back(($urandom % 3 == 0) ? esc : 8'h21 + 8'($urandom % 94));
      s.push_back(esc ^ 8'h01);
      u_remote.mode = k % 2;
      run_stream(s, esc);
      if (op_status === CON) begin
        s = {esc, esc, esc};
        run_stream(s, esc);
      end
    end
    esc = 8'h2B;
    do_cmd(3'h1, esc);
    for (int sel = 1; sel < 4; sel++) begin
      do_cmd(3'h5, 8'(sel));
      check({got_resp, got_code, op_status}, {1'b1, R_OK, PND});
      check({inquiry_scan_en, page_scan_en}, {sel[0], sel[1]});
      do_cmd(3'h3, 8'h00);
      check({got_resp, got_code, op_status, inquiry_scan_en, page_scan_en}, {1'b1, R_OK, STB, 2'b00});
    end
    // a limited wait gives up after two timer periods with ERROR
    cmd_timeout = 16'h0002;
    do_cmd(3'h5, 8'h03);
    cmd_timeout = 16'h0000;
    check({got_resp, got_code, op_status}, {1'b1, R_OK, PND});
    repeat (2 * SEC - 2) @(posedge clk_sys);
    #5 check(op_status, PND);
    @(posedge clk_sys) #5;
    check({resp_valid, resp_code, op_status}, {1'b1, esc_link_pkg::RESP_ERROR, STB});
    do_cmd(3'h4, 8'h00);
    check({got_resp, got_code, op_status, inquiry_scan_en, page_scan_en}, {1'b1, R_OK, PND, 2'b11});
    repeat (3 * SEC) @(posedge clk_sys);
    #5 check(op_status, PND);
    addr = 48'({$urandom(), $urandom()});
    u_remote.link_up(addr);
    check({resp_valid, resp_code, resp_addr, op_status}, {1'b1, esc_link_pkg::RESP_CONNECT, addr, CON});
    u_remote.mode = 0;
    run_stream(to_q("hi+j"), esc);
    u_remote.link_down();
    check(op_status, PND);
    do_cmd(3'h3, 8'h00);
    check({got_resp, got_code, op_status}, {1'b1, R_OK, STB});
    close_out();
  end
endmodule
